// File: shared/usp_pkg.sv
// Register map, field positions and bus carrier of the slave serial port
package usp_pkg;
   localparam logic [7:0] ADDR_INT_CTRL = 8'h0B;
   localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_RX_STATUS = 8'h18;
   localparam logic [7:0] ADDR_TX_BUF = 8'h19;
   localparam logic [7:0] ADDR_RX_BUF = 8'h1A;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h8C;
   localparam logic [7:0] ADDR_TX_STATUS = 8'h98;
   localparam logic [7:0] ADDR_BAUD_DIV = 8'h99;

   // Interrupt control fields
   localparam int unsigned GLB_IE_BIT = 7;
   localparam int unsigned PER_IE_BIT = 6;
   // Flag and enable fields (same positions in both registers)
   localparam int unsigned RXF_BIT = 5;
   localparam int unsigned TXE_BIT = 4;
   // Receive status fields
   localparam int unsigned PORT_EN_BIT = 7;
   localparam int unsigned RX_NINE_SEL_BIT = 6;
   localparam int unsigned SINGLE_RX_BIT = 5;
   localparam int unsigned CONT_RX_BIT = 4;
   localparam int unsigned FRAME_ERR_BIT = 2;
   localparam int unsigned OVERRUN_BIT = 1;
   localparam int unsigned RX_NINTH_BIT = 0;
   // Transmit status fields
   localparam int unsigned CLK_SRC_BIT = 7;
   localparam int unsigned TX_NINE_SEL_BIT = 6;
   localparam int unsigned TX_EN_BIT = 5;
   localparam int unsigned SYNC_MODE_BIT = 4;
   localparam int unsigned SHIFTER_EMPTY_BIT = 1;
   localparam int unsigned TX_NINTH_BIT = 0;

   // Reset values and writable masks
   localparam logic [7:0] DATA_ZERO = 8'h00;
   localparam logic [7:0] TX_STATUS_RST = 8'h02;
   localparam logic [7:0] FLAGS_WMASK = 8'hCF;
   localparam logic [7:0] RX_STATUS_WMASK = 8'hF8;
   localparam logic [7:0] TX_STATUS_WMASK = 8'hF5;

   // Word lengths and receive buffer fill levels
   localparam logic [3:0] BITS_EIGHT = 4'h8;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [1:0] FILL_ZERO = 2'h0;
   localparam logic [1:0] FIFO_FULL = 2'h2;
   localparam int unsigned FIFO_DEPTH = 2;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } usp_bus_req_t;

   typedef logic [8:0] usp_word_t;
endpackage

// File: hw/usp_top.sv
// Synchronous slave serial port: registers, shifters and receive buffer
`timescale 1ns/1ps
// Summary of operation
// R1 - Shift clock always comes from outside master
// R2 - Slave mode when clock source bit clear
// R3 - Second queued word waits, empty flag clear
// R4 - Refill shifter, then set empty flag
// R5 - Transmit flag with enable wakes the core
// R6 - Software sets sync, port enable, clears source
// R7 - Software clears both receive enables first
// R8 - Nine-bit transmit select sends nine bits
// R9 - Software loads ninth bit before data
// R10 - Transmit only while transmit enable set
// R11 - Buffer write starts word transmission
// R12 - Shifting works identically to master mode
// R13 - Single receive enable ignored in slave
// R14 - Continuous receive completes word while asleep
// R15 - Finished word moves to buffer, may wake
// R16 - Nine-bit receive select receives nine bits
// R17 - Full flag on completion, irq if enabled
// R18 - Software reads status before receive data
// R19 - Clearing continuous receive clears overrun
// R20 - Irq needs global and peripheral enables
// R21 - Sample data at shift clock falling edge
// R22 - Third word when full sets overrun, dropped
// R23 - Overrun blocks shifter to buffer transfers
// R24 - Buffer read exposes next word's ninth bit
// R25 - Clock pin is never driven
module usp_top (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire usp_pkg::usp_bus_req_t bus_req,
   output logic [7:0] bus_rdata,
   input wire logic shift_clock_sense,
   output logic shift_clock_drive,
   output logic shift_clock_drive_en,
   input wire logic serial_data_sense,
   output logic serial_data_drive,
   output logic serial_data_drive_en,
   output logic core_wake,
   output logic core_irq,
   output logic [12:0] irq_vector
);
   import usp_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   logic ck_s1_q, ck_s2_q, ck_s3_q, dt_s1_q, dt_s2_q, ck_fall;
   logic [7:0] int_ctrl_q, flag_store_q, rx_ctrl_q, tx_ctrl_q;
   logic [7:0] tx_buf_q, irq_en_q, baud_div_q, rd_mux;
   logic wr_int, wr_flg, wr_rxs, wr_txb, wr_ien, wr_txs, wr_bd, rd_rxb;
   logic port_en, cont_rx, rx_nine, tx_nine, tx_en, clk_src, sync_mode;
   logic slave_act, rx_act, tx_go, tx_load, transmit_buffer_empty_flag, receive_buffer_full_flag;
   logic tx_busy_q, tx_full_q;
   logic [8:0] tx_sh_q, rx_sh_q, rx_next, rx_word;
   logic [3:0] tx_cnt_q, rx_cnt_q, rx_len;
   logic rx_done, rx_push, rx_pop, rd_ptr_q, wr_ptr, overrun_error_flag_q;
   logic rx_ninth, tail_ninth;
   logic [1:0] fill_q;
   usp_word_t fifo_q [FIFO_DEPTH];

   // Pin synchronisers; the first stage feeds only the second
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ck_s1_q <= 1'h0;
         ck_s2_q <= 1'h0;
         ck_s3_q <= 1'h0;
         dt_s1_q <= 1'h0;
         dt_s2_q <= 1'h0;
      end else if (clk_en) begin
         ck_s1_q <= shift_clock_sense;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         dt_s1_q <= serial_data_sense;
         dt_s2_q <= dt_s1_q;
      end
   end

   // External clock edges drive both shifters
   assign ck_fall = ck_s3_q & ~ck_s2_q; // [R1] [R21] [R12]

   assign wr_int = bus_req.wr & hit(bus_req.addr, ADDR_INT_CTRL);
   assign wr_flg = bus_req.wr & hit(bus_req.addr, ADDR_IRQ_FLAGS);
   assign wr_rxs = bus_req.wr & hit(bus_req.addr, ADDR_RX_STATUS);
   assign wr_txb = bus_req.wr & hit(bus_req.addr, ADDR_TX_BUF);
   assign wr_ien = bus_req.wr & hit(bus_req.addr, ADDR_IRQ_EN);
   assign wr_txs = bus_req.wr & hit(bus_req.addr, ADDR_TX_STATUS);
   assign wr_bd = bus_req.wr & hit(bus_req.addr, ADDR_BAUD_DIV);
   assign rd_rxb = bus_req.rd & hit(bus_req.addr, ADDR_RX_BUF);

   // Software-visible control registers
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         int_ctrl_q <= DATA_ZERO;
         flag_store_q <= DATA_ZERO;
         rx_ctrl_q <= DATA_ZERO;
         tx_ctrl_q <= TX_STATUS_RST & TX_STATUS_WMASK;
         tx_buf_q <= DATA_ZERO;
         irq_en_q <= DATA_ZERO;
         baud_div_q <= DATA_ZERO;
      end else if (clk_en) begin
         if (wr_int) begin
            int_ctrl_q <= bus_req.wdata;
         end
         if (wr_flg) begin
            flag_store_q <= bus_req.wdata & FLAGS_WMASK;
         end
         if (wr_rxs) begin
            rx_ctrl_q <= bus_req.wdata & RX_STATUS_WMASK;
         end
         if (wr_txs) begin
            tx_ctrl_q <= bus_req.wdata & TX_STATUS_WMASK;
         end
         if (wr_txb) begin
            tx_buf_q <= bus_req.wdata;
         end
         if (wr_ien) begin
            irq_en_q <= bus_req.wdata;
         end
         if (wr_bd) begin
            baud_div_q <= bus_req.wdata;
         end
      end
   end

   assign port_en = rx_ctrl_q[PORT_EN_BIT];
   assign cont_rx = rx_ctrl_q[CONT_RX_BIT];
   assign rx_nine = rx_ctrl_q[RX_NINE_SEL_BIT];
   assign tx_nine = tx_ctrl_q[TX_NINE_SEL_BIT];
   assign tx_en = tx_ctrl_q[TX_EN_BIT];
   assign clk_src = tx_ctrl_q[CLK_SRC_BIT];
   assign sync_mode = tx_ctrl_q[SYNC_MODE_BIT];

   // Master clocking is not built, so a set source bit idles the port
   assign slave_act = port_en & sync_mode & ~clk_src; // [R2]
   // Single receive enable plays no part here
   assign rx_act = slave_act & cont_rx; // [R13] [R14]
   // Link is half duplex; reception wins the data pin
   assign tx_go = slave_act & tx_en & ~rx_act; // [R10]
   assign tx_load = tx_go & tx_full_q & ~tx_busy_q; // [R3]
   assign transmit_buffer_empty_flag = ~tx_full_q; // [R4]
   assign receive_buffer_full_flag = fill_q != FILL_ZERO; // [R17]

   // Transmit buffer occupancy; a write wins over a same-cycle load
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tx_full_q <= 1'h0;
      end else if (clk_en) begin
         tx_full_q <= (tx_full_q & ~tx_load) | wr_txb; // [R11] [R3]
      end
   end

   // Transmit shifter, LSB first, one bit per external falling edge
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         tx_busy_q <= 1'h0;
         tx_cnt_q <= BITS_EIGHT;
         tx_sh_q <= {1'h0, DATA_ZERO};
      end else if (clk_en) begin
         if (!tx_go) begin
            tx_busy_q <= 1'h0; // [R10]
            tx_cnt_q <= BITS_EIGHT;
         end else if (tx_load) begin
            tx_sh_q <= {tx_ctrl_q[TX_NINTH_BIT], tx_buf_q}; // [R11]
            tx_cnt_q <= tx_nine ? BITS_NINE : BITS_EIGHT; // [R8]
            tx_busy_q <= 1'h1;
         end else if (tx_busy_q && ck_fall) begin
            tx_sh_q <= tx_sh_q >> 1;
            tx_cnt_q <= tx_cnt_q - CNT_ONE;
            if (tx_cnt_q == CNT_ONE) begin
               tx_busy_q <= 1'h0; // [R4]
            end
         end
      end
   end

   assign serial_data_drive = tx_sh_q[0];
   assign serial_data_drive_en = tx_busy_q; // [R10]
   // The pin is only ever sensed; no internal clock reaches it
   assign shift_clock_drive = 1'h0; // [R25]
   assign shift_clock_drive_en = 1'h0; // [R25] [R1]

   // Receive shifter
   assign rx_len = rx_nine ? BITS_NINE : BITS_EIGHT; // [R16]
   assign rx_next = {dt_s2_q, rx_sh_q[8:1]}; // [R21]
   assign rx_done = rx_act & ck_fall & (rx_cnt_q == CNT_ONE);
   assign rx_word = rx_nine ? rx_next : {1'h0, rx_next[8:1]}; // [R16]

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rx_cnt_q <= BITS_EIGHT;
         rx_sh_q <= {1'h0, DATA_ZERO};
      end else if (clk_en) begin
         if (!rx_act) begin
            // Take a select written now, or the first word is cut short
            rx_cnt_q <= (wr_rxs ? bus_req.wdata[RX_NINE_SEL_BIT] : rx_nine)
               ? BITS_NINE : BITS_EIGHT; // [R16]
         end else if (ck_fall) begin
            rx_sh_q <= rx_next;
            if (rx_cnt_q == CNT_ONE) begin
               rx_cnt_q <= rx_len;
            end else begin
               rx_cnt_q <= rx_cnt_q - CNT_ONE;
            end
         end
      end
   end

   // Two-deep receive buffer
   assign rx_push = rx_done & ~overrun_error_flag_q & (fill_q != FIFO_FULL); // [R15] [R23]
   assign rx_pop = rd_rxb & receive_buffer_full_flag;
   assign wr_ptr = rd_ptr_q ^ fill_q[0];
   assign rx_ninth = fifo_q[rd_ptr_q][8]; // [R24]
   assign tail_ninth = fifo_q[~rd_ptr_q][8];

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         fill_q <= FILL_ZERO;
         rd_ptr_q <= 1'h0;
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            fifo_q[i] <= {1'h0, DATA_ZERO};
         end
      end else if (clk_en) begin
         if (rx_push) begin
            fifo_q[wr_ptr] <= rx_word; // [R15]
         end
         if (rx_pop) begin
            rd_ptr_q <= ~rd_ptr_q; // [R24]
         end
         fill_q <= fill_q + {1'h0, rx_push} - {1'h0, rx_pop}; // [R22]
      end
   end

   // Overrun is sticky until continuous receive is cleared
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         overrun_error_flag_q <= 1'h0;
      end else if (clk_en) begin
         if (rx_done && fill_q == FIFO_FULL) begin
            overrun_error_flag_q <= 1'h1; // [R22]
         end else if (!cont_rx) begin
            overrun_error_flag_q <= 1'h0; // [R19]
         end
      end
   end

   // Read mux with status views built from live state
   always_comb begin
      rd_mux = DATA_ZERO;
      case (bus_req.addr)
         ADDR_INT_CTRL: rd_mux = int_ctrl_q;
         ADDR_IRQ_FLAGS: begin
            rd_mux = flag_store_q;
            rd_mux[RXF_BIT] = receive_buffer_full_flag;
            rd_mux[TXE_BIT] = transmit_buffer_empty_flag;
         end
         ADDR_RX_STATUS: begin
            rd_mux = rx_ctrl_q;
            rd_mux[FRAME_ERR_BIT] = 1'h0;
            rd_mux[OVERRUN_BIT] = overrun_error_flag_q;
            rd_mux[RX_NINTH_BIT] = rx_ninth; // [R24]
         end
         ADDR_RX_BUF: rd_mux = fifo_q[rd_ptr_q][7:0];
         ADDR_IRQ_EN: rd_mux = irq_en_q;
         ADDR_TX_STATUS: begin
            rd_mux = tx_ctrl_q;
            rd_mux[SHIFTER_EMPTY_BIT] = ~tx_busy_q;
         end
         ADDR_BAUD_DIV: rd_mux = baud_div_q;
         default: rd_mux = DATA_ZERO;
      endcase
   end

   // Read data stand for exactly one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         bus_rdata <= DATA_ZERO;
      end else if (clk_en) begin
         bus_rdata <= bus_req.rd ? rd_mux : DATA_ZERO;
      end
   end

   // Wake ignores the global gates so sleep exits even with irqs off
   assign core_wake = (transmit_buffer_empty_flag & irq_en_q[TXE_BIT])
      | (receive_buffer_full_flag & irq_en_q[RXF_BIT]); // [R5] [R15] [R17]
   assign core_irq = core_wake & int_ctrl_q[GLB_IE_BIT]
      & int_ctrl_q[PER_IE_BIT]; // [R20]
   assign irq_vector = IRQ_VECTOR; // [R5]

   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   slave_gate_a: assert property ( // [R2]
      clk_en && !slave_act |=> !tx_busy_q)
      else $error("shifter busy outside slave mode");
   tx_start_a: assert property ( // [R11]
      clk_en && wr_txb && !tx_full_q && !tx_busy_q && tx_go
      ##1 clk_en && tx_go
      |=> tx_busy_q && tx_sh_q[7:0] == $past(bus_req.wdata, 2))
      else $error("buffer write did not start the word");
   tx_hold_a: assert property ( // [R3]
      tx_busy_q && tx_full_q |-> !transmit_buffer_empty_flag && !tx_load)
      else $error("queued word or flag mishandled");
   tx_refill_a: assert property ( // [R4]
      clk_en && tx_go && tx_busy_q && ck_fall && tx_cnt_q == CNT_ONE
      && tx_full_q ##1 clk_en && tx_go && !wr_txb
      |=> tx_busy_q && transmit_buffer_empty_flag)
      else $error("second word not moved to shifter");
   tx_enable_a: assert property ( // [R10]
      clk_en && !tx_en |=> !serial_data_drive_en)
      else $error("data driven without transmit enable");
   nine_bit_a: assert property ( // [R8]
      clk_en && tx_load && tx_nine |=> tx_cnt_q == BITS_NINE)
      else $error("nine-bit word not loaded");
   rx_flag_a: assert property ( // [R17]
      clk_en && rx_push |=> receive_buffer_full_flag)
      else $error("full flag not set on completion");
   overrun_a: assert property ( // [R22]
      clk_en && rx_done && fill_q == FIFO_FULL |=> overrun_error_flag_q && receive_buffer_full_flag)
      else $error("overrun not flagged");
   overrun_error_flag_block_a: assert property ( // [R23]
      clk_en && overrun_error_flag_q |=> fill_q <= $past(fill_q))
      else $error("transfer while overrun set");
   err_clear_a: assert property ( // [R19]
      clk_en && !cont_rx |=> !overrun_error_flag_q)
      else $error("overrun survived receive disable");
   irq_gate_a: assert property ( // [R20]
      core_irq |-> int_ctrl_q[GLB_IE_BIT] && int_ctrl_q[PER_IE_BIT])
      else $error("irq without global enables");
   ninth_load_a: assert property ( // [R24]
      clk_en && rx_pop && fill_q == FIFO_FULL
      |=> rx_ninth == $past(tail_ninth))
      else $error("ninth bit not advanced on read");
   no_clk_drive_a: assert property ( // [R25]
      !shift_clock_drive_en)
      else $error("clock pin driven");

   two_words_c: cover property (tx_busy_q && tx_full_q ##[1:400] tx_load);
   overrun_c: cover property (rx_done && fill_q == FIFO_FULL);
   nine_rx_c: cover property (rx_push && rx_nine);
   irq_c: cover property (core_irq);
endmodule // usp_top

// File: testbench/usp_link_master.sv
// Outside synchronous master that clocks the slave port's link
`timescale 1ns/1ps
module usp_link_master (
   input wire logic go,
   input wire logic [3:0] nbits,
   input wire logic [8:0] word_out,
   input wire logic sdata,
   output logic sck,
   output logic sdo,
   output logic [8:0] word_in,
   output logic busy
);
   initial begin
      sck = 1'b1;
      sdo = 1'b0;
      word_in = 9'h000;
      busy = 1'b0;
   end
   // Clock idles high and runs only inside a frame
   always @(posedge go) begin
      busy = 1'b1;
      word_in = 9'h000;
      #7;
      for (int i = 0; i < int'(nbits); i++) begin
         sdo = word_out[i];
         #50;
         word_in[i] = sdata;
         sck = 1'b0;
         #100;
         sck = 1'b1;
         #50;
      end
      // Released line shows the inverse, never a stale level
      sdo = ~sdo;
      busy = 1'b0;
   end
endmodule // usp_link_master

// File: testbench/usart_sync_slave_port_test.sv
// Register-level tests of the slave serial port against a link master
`timescale 1ns/1ps
module usart_sync_slave_port_test;
   import usp_pkg::*;
   logic mclk, sys_rst, go, sck, sdo, mbusy, core_wake, core_irq;
   logic drv, drv_en, ck_drv, ck_en, wire_d, ce;
   logic [7:0] rdata;
   logic [3:0] nbits;
   logic [8:0] word_out, word_in;
   logic [12:0] vec;
   usp_bus_req_t bus_req;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [7:0] raddr [8] = '{ADDR_INT_CTRL, ADDR_RX_STATUS, ADDR_TX_BUF,
      ADDR_RX_BUF, ADDR_IRQ_EN, ADDR_TX_STATUS, ADDR_BAUD_DIV, 8'h55};
   logic [7:0] rrst [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
      8'h00, 8'h00};
   logic [8:0] ow [4] = '{9'h011, 9'h022, 9'h033, 9'h044};

   // Device drives the data line only while it shifts a word out
   assign wire_d = drv_en ? drv : sdo;

   usp_top usp_top_inst (.mclk(mclk), .sys_rst(sys_rst), .clk_en(ce),
      .bus_req(bus_req), .bus_rdata(rdata), .shift_clock_sense(sck),
      .shift_clock_drive(ck_drv), .shift_clock_drive_en(ck_en),
      .serial_data_sense(wire_d), .serial_data_drive(drv),
      .serial_data_drive_en(drv_en), .core_wake(core_wake),
      .core_irq(core_irq), .irq_vector(vec));

   usp_link_master usp_link_master_inst (.go(go), .nbits(nbits),
      .word_out(word_out), .sdata(wire_d), .sck(sck), .sdo(sdo),
      .word_in(word_in), .busy(mbusy));

   task automatic close_out;
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
      @(posedge mclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      #1;
      chk(16'(rdata), 16'(e));
      @(posedge mclk);
   endtask

   // Pins are looked at mid-cycle, away from any edge's updates
   task automatic ck_pins(input logic [15:0] e_wake, input logic [15:0] e_irq);
      @(negedge mclk);
      chk(16'(core_wake), e_wake);
      chk(16'(core_irq), e_irq);
      @(posedge mclk);
   endtask

   task automatic frame(input logic [3:0] n, input logic [8:0] w);
      int k;
      nbits <= n;
      word_out <= w;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (mbusy !== 1'b0 && k < 400);
      chk(16'(mbusy), 16'h0000);
      // Synchroniser delay before the word lands in the buffer
      repeat (6) @(posedge mclk);
      chk(16'(ck_en), 16'h0000);
      chk(16'(ck_drv), 16'h0000);
   endtask

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   initial begin
      sys_rst = 1'b1;
      go = 1'b0;
      ce = 1'b1;
      nbits = 4'h8;
      word_out = 9'h000;
      bus_req = '0;
      repeat (5) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      // Reset values; write-only buffer and an unmapped place read zero
      foreach (raddr[i]) rd(raddr[i], rrst[i]);
      wr(ADDR_BAUD_DIV, 8'hA5);
      wr(8'h55, 8'h3C);
      rd(ADDR_BAUD_DIV, 8'hA5);
      rd(8'h55, 8'h00);
      // A frozen clock enable must swallow the write
      ce <= 1'b0;
      wr(ADDR_BAUD_DIV, 8'h5A);
      ce <= 1'b1;
      rd(ADDR_BAUD_DIV, 8'hA5);
      chk(16'(vec), 16'(IRQ_VECTOR));
      // Transmit with the single receive bit set, which must not matter
      wr(ADDR_RX_STATUS, 8'hA0);
      wr(ADDR_TX_STATUS, 8'h30);
      wr(ADDR_IRQ_EN, 8'h10);
      wr(ADDR_TX_BUF, 8'h3C);
      wr(ADDR_TX_BUF, 8'hA5);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      ck_pins(16'h0000, 16'h0000);
      frame(4'h8, 9'h000);
      chk(16'(word_in), 16'h003C);
      chk(16'(drv_en), 16'h0001);
      rd(ADDR_IRQ_FLAGS, 8'h10);
      ck_pins(16'h0001, 16'h0000);
      wr(ADDR_INT_CTRL, 8'h80);
      ck_pins(16'h0001, 16'h0000);
      wr(ADDR_INT_CTRL, 8'hC0);
      ck_pins(16'h0001, 16'h0001);
      frame(4'h8, 9'h000);
      chk(16'(word_in), 16'h00A5);
      wr(ADDR_RX_STATUS, 8'h80);
      wr(ADDR_TX_STATUS, 8'h71);
      wr(ADDR_TX_BUF, 8'h5A);
      frame(4'h9, 9'h000);
      chk(16'(word_in), 16'h015A);
      // With transmit disabled a queued word must stay put
      wr(ADDR_TX_STATUS, 8'h10);
      wr(ADDR_TX_BUF, 8'h77);
      repeat (3) @(posedge mclk);
      chk(16'(drv_en), 16'h0000);
      // Continuous receive
      wr(ADDR_IRQ_EN, 8'h20);
      wr(ADDR_RX_STATUS, 8'h90);
      frame(4'h8, 9'h096);
      rd(ADDR_IRQ_FLAGS, 8'h20);
      ck_pins(16'h0001, 16'h0001);
      rd(ADDR_RX_STATUS, 8'h90);
      rd(ADDR_RX_BUF, 8'h96);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      // Four words into a two-deep buffer: overrun, then nothing moves
      foreach (ow[i]) frame(4'h8, ow[i]);
      rd(ADDR_RX_STATUS, 8'h92);
      rd(ADDR_RX_BUF, 8'h11);
      rd(ADDR_RX_BUF, 8'h22);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      // Buffer has room now, yet the sticky overrun must still block
      frame(4'h8, 9'h055);
      rd(ADDR_IRQ_FLAGS, 8'h00);
      wr(ADDR_RX_STATUS, 8'h80);
      rd(ADDR_RX_STATUS, 8'h80);
      // Nine-bit receive, ninth bit follows the head of the buffer
      wr(ADDR_RX_STATUS, 8'hD0);
      frame(4'h9, 9'h1AB);
      frame(4'h9, 9'h0CD);
      rd(ADDR_RX_STATUS, 8'hD1);
      rd(ADDR_RX_BUF, 8'hAB);
      rd(ADDR_RX_STATUS, 8'hD0);
      rd(ADDR_RX_BUF, 8'hCD);
      close_out();
   end
endmodule // usart_sync_slave_port_test
